// File: shared/flash_host_pkg.sv
// Constants for the parallel flash host controller.
// Assumes a 25 MHz controller clock and a byte-wide flash on the pins.
package flash_host_pkg;

	// --------------------------------------------------------------
	// Clock and timing
	// --------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int T_RESET_PULSE_NS = 500;
	localparam int T_READY_ALG_NS = 20000;
	localparam int T_READY_IDLE_NS = 500;
	localparam int T_RESET_HIGH_NS = 50;
	localparam int T_ACCESS_NS = 90;
	localparam int T_WRITE_PULSE_NS = 35;
	localparam int T_WRITE_HIGH_NS = 30;
	localparam int T_BUSY_NS = 90;

	localparam int CW = 16;
	localparam logic [CW-1:0] RESET_PULSE_CYC =
		CW'((T_RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] READY_ALG_CYC =
		CW'((T_READY_ALG_NS + T_RESET_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] READY_IDLE_CYC =
		CW'((T_READY_IDLE_NS + T_RESET_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] ACCESS_CYC =
		CW'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] WRITE_PULSE_CYC =
		CW'((T_WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] WRITE_HIGH_CYC =
		CW'((T_WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] BUSY_CYC =
		CW'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);

	// --------------------------------------------------------------
	// Operations requested by the user
	// --------------------------------------------------------------
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_RESET = 3'h2;
	localparam logic [2:0] OP_ID_ENTER = 3'h3;
	localparam logic [2:0] OP_ID_EXIT = 3'h4;
	localparam logic [2:0] OP_ID_HV = 3'h5;
	localparam logic [2:0] OP_PROTECT = 3'h6;
	localparam logic [2:0] OP_UNPROTECT = 3'h7;

	// --------------------------------------------------------------
	// Command cycles and address fields
	// --------------------------------------------------------------
	localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
	localparam logic [18:0] UNLOCK2_ADDR = 19'h002aa;
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] DATA_NONE = 8'h00;
	localparam logic [18:0] SECTOR_MASK = 19'h7e000;
	localparam int A6_BIT = 6;
	localparam int A1_BIT = 1;
	localparam int A0_BIT = 0;
	localparam logic [3:0] SECTOR_COUNT = 4'hb;

	// Sector base addresses, index 0 in the rightmost slot.
	localparam logic [10:0][18:0] TOP_BASE = {
		19'h7c000, 19'h7a000, 19'h78000, 19'h70000, 19'h60000,
		19'h50000, 19'h40000, 19'h30000, 19'h20000, 19'h10000,
		19'h00000};
	localparam logic [10:0][18:0] BOTTOM_BASE = {
		19'h70000, 19'h60000, 19'h50000, 19'h40000, 19'h30000,
		19'h20000, 19'h10000, 19'h08000, 19'h06000, 19'h04000,
		19'h00000};

	// --------------------------------------------------------------
	// Controller states
	// --------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_READ = 7'h02,
		ST_WR_SETUP = 7'h04,
		ST_WR_LOW = 7'h08,
		ST_WR_HIGH = 7'h10,
		ST_BUSY_WAIT = 7'h20,
		ST_RST_LOW = 7'h40
	} state_t;

endpackage

// File: hw/flash_host.sv
// Host controller that drives a byte-wide boot-sector flash over its pins.
// Assumes the flash bus inputs are synchronous to mclk and that external
// level shifters turn reset_hv and a9_hv into the high-voltage levels.
//
// Summary of operation
// RULE1: Reset pin low for minimum pulse time.
// RULE2: Device returns to read array after reset.
// RULE3: Wait for ready after reset during algorithm.
// RULE4: Wait shorter settle when reset while idle.
// RULE5: Report aborted operation so user reissues it.
// RULE6: Top boot sector bases per address bits.
// RULE7: Bottom boot sector bases per address bits.
// RULE8: A9 high voltage, A6 low reads IDs.
// RULE9: A1 high, A0 low verifies sector protection.
// RULE10: Enter identification mode by command sequence.
// RULE11: Protected sectors refuse program and erase.
// RULE12: Unprotect reenables program and erase.
// RULE13: Protect all sectors before unprotect write.
// RULE14: Sectors arrive unprotected.
// RULE15: Strobe pulses far longer than glitch width.
// RULE16: Write only with select, strobe low, gate high.
// RULE17: Strobe held high from reset onward.
// RULE18: Reads need no command after power up.
// RULE19: Program preceded by unlock cycles.
// RULE20: Protect selected by reset high voltage only.
// RULE21: High voltage removed after each protect operation.
// RULE22: Leave identification mode with reset command.
// RULE23: High voltage given as separate qualifiers.
`timescale 1ns/10ps

module flash_host #(
	parameter bit BOTTOM_BOOT = 1'b0,
	parameter logic [15:0] READY_ALG_CYCLES = flash_host_pkg::READY_ALG_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_op,
	input wire logic [18:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_aborted,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic [18:0] flash_addr,
	input wire logic [7:0] flash_dq_in,
	output logic [7:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic flash_reset_n,
	output logic reset_hv,
	output logic a9_hv,
	input wire logic ready_busy_n
);

	// --------------------------------------------------------------
	// State record
	// --------------------------------------------------------------
	typedef struct packed {
		flash_host_pkg::state_t st;
		logic [15:0] cnt;
		logic [3:0] step;
		logic [2:0] op;
		logic [18:0] uaddr;
		logic [7:0] udata;
		logic was_busy;
		logic is_reset;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [18:0] addr;
		logic [7:0] dq_out;
		logic dq_oe;
		logic reset_n;
		logic reset_hv;
		logic a9_hv;
		logic cmd_ready;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic rsp_aborted;
	} host_t;

	host_t s;
	host_t next_s;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [18:0] sector_base(input logic [3:0] idx);
		if (BOTTOM_BOOT) begin
			return flash_host_pkg::BOTTOM_BASE[idx]; // [RULE7]
		end
		return flash_host_pkg::TOP_BASE[idx]; // [RULE6]
	endfunction

	function automatic logic [18:0] prot_addr(input logic [18:0] a,
		input logic unprot);
		logic [18:0] r;
		r = a & flash_host_pkg::SECTOR_MASK;
		r[flash_host_pkg::A1_BIT] = 1'b1;
		r[flash_host_pkg::A0_BIT] = 1'b0;
		r[flash_host_pkg::A6_BIT] = unprot;
		return r;
	endfunction

	// Address and data of one write step of a command sequence.
	function automatic logic [26:0] seq_word(input logic [2:0] op,
		input logic [3:0] step, input logic [18:0] a, input logic [7:0] d);
		logic [26:0] w;
		w = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA};
		case (op)
		flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_ID_ENTER: begin
			if (step == 4'h1) begin
				w = {flash_host_pkg::UNLOCK2_ADDR,
					flash_host_pkg::UNLOCK2_DATA};
			end else if (step == 4'h2) begin
				w = {flash_host_pkg::UNLOCK1_ADDR,
					(op == flash_host_pkg::OP_PROGRAM) ?
					flash_host_pkg::CMD_PROGRAM :
					flash_host_pkg::CMD_AUTOSELECT}; // [RULE10]
			end else if (step == 4'h3) begin
				w = {a, d}; // [RULE19]
			end
		end
		flash_host_pkg::OP_ID_EXIT: begin
			w = {a, flash_host_pkg::CMD_RESET}; // [RULE22]
		end
		flash_host_pkg::OP_PROTECT: begin
			w = {prot_addr(a, 1'b0), flash_host_pkg::DATA_NONE};
		end
		default: begin
			if (step < flash_host_pkg::SECTOR_COUNT) begin
				w = {prot_addr(sector_base(step), 1'b0),
					flash_host_pkg::DATA_NONE}; // [RULE13]
			end else begin
				w = {prot_addr(a, 1'b1), flash_host_pkg::DATA_NONE};
			end
		end
		endcase
		return w;
	endfunction

	function automatic logic seq_last(input logic [2:0] op,
		input logic [3:0] step);
		case (op)
		flash_host_pkg::OP_PROGRAM: return step == 4'h3;
		flash_host_pkg::OP_ID_ENTER: return step == 4'h2;
		flash_host_pkg::OP_UNPROTECT:
			return step == flash_host_pkg::SECTOR_COUNT;
		default: return 1'b1;
		endcase
	endfunction

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		logic [26:0] w;
		w = seq_word(s.op, s.step, s.uaddr, s.udata);
		next_s = s;
		next_s.rsp_valid = 1'b0;
		if (s.cnt != 16'h0000) begin
			next_s.cnt = s.cnt - 16'h0001;
		end
		case (s.st)
		flash_host_pkg::ST_IDLE: begin
			if (cmd_valid && s.cmd_ready) begin
				next_s.cmd_ready = 1'b0;
				next_s.op = cmd_op;
				next_s.uaddr = cmd_addr;
				next_s.udata = cmd_data;
				next_s.step = 4'h0;
				next_s.rsp_aborted = 1'b0;
				next_s.is_reset = 1'b0;
				if (cmd_op == flash_host_pkg::OP_READ ||
					cmd_op == flash_host_pkg::OP_ID_HV) begin
					// Plain reads need no command first. [RULE18]
					next_s.addr = cmd_addr;
					if (cmd_op == flash_host_pkg::OP_ID_HV) begin
						next_s.addr[flash_host_pkg::A6_BIT] = 1'b0; // [RULE8]
						next_s.a9_hv = 1'b1; // [RULE8] [RULE9] [RULE23]
					end
					next_s.ce_n = 1'b0;
					next_s.oe_n = 1'b0;
					next_s.cnt = flash_host_pkg::ACCESS_CYC;
					next_s.st = flash_host_pkg::ST_READ;
				end else if (cmd_op == flash_host_pkg::OP_RESET) begin
					next_s.reset_n = 1'b0; // [RULE1]
					next_s.was_busy = ~ready_busy_n;
					next_s.is_reset = 1'b1;
					next_s.cnt = flash_host_pkg::RESET_PULSE_CYC;
					next_s.st = flash_host_pkg::ST_RST_LOW;
				end else begin
					next_s.reset_hv =
						cmd_op == flash_host_pkg::OP_PROTECT ||
						cmd_op == flash_host_pkg::OP_UNPROTECT; // [RULE20] [RULE23]
					next_s.st = flash_host_pkg::ST_WR_SETUP;
				end
			end
		end
		flash_host_pkg::ST_READ: begin
			if (s.cnt == 16'h0000) begin
				next_s.rsp_data = flash_dq_in;
				next_s.ce_n = 1'b1;
				next_s.oe_n = 1'b1;
				next_s.a9_hv = 1'b0;
				next_s.rsp_valid = 1'b1;
				next_s.cmd_ready = 1'b1;
				next_s.st = flash_host_pkg::ST_IDLE;
			end
		end
		flash_host_pkg::ST_WR_SETUP: begin
			next_s.addr = w[26:8];
			next_s.dq_out = w[7:0];
			next_s.dq_oe = 1'b1;
			next_s.oe_n = 1'b1;
			next_s.ce_n = 1'b0;
			next_s.st = flash_host_pkg::ST_WR_LOW;
			next_s.cnt = flash_host_pkg::WRITE_PULSE_CYC;
		end
		flash_host_pkg::ST_WR_LOW: begin
			next_s.we_n = 1'b0; // [RULE16]
			if (s.cnt == 16'h0000 && !s.we_n) begin
				next_s.we_n = 1'b1; // [RULE15]
				next_s.ce_n = 1'b1;
				next_s.cnt = flash_host_pkg::WRITE_HIGH_CYC;
				next_s.st = flash_host_pkg::ST_WR_HIGH;
			end
		end
		flash_host_pkg::ST_WR_HIGH: begin
			if (s.cnt == 16'h0000) begin
				next_s.dq_oe = 1'b0;
				next_s.cnt = flash_host_pkg::BUSY_CYC;
				next_s.st = flash_host_pkg::ST_BUSY_WAIT;
			end
		end
		flash_host_pkg::ST_BUSY_WAIT: begin
			if (s.cnt == 16'h0000 && ready_busy_n) begin // [RULE3] [RULE4]
				if (!s.is_reset && !seq_last(s.op, s.step)) begin
					next_s.step = s.step + 4'h1;
					next_s.st = flash_host_pkg::ST_WR_SETUP;
				end else begin
					next_s.reset_hv = 1'b0; // [RULE21]
					next_s.rsp_aborted = s.is_reset & s.was_busy; // [RULE5]
					next_s.rsp_valid = 1'b1;
					next_s.cmd_ready = 1'b1;
					next_s.st = flash_host_pkg::ST_IDLE;
				end
			end
		end
		flash_host_pkg::ST_RST_LOW: begin
			if (s.cnt == 16'h0000) begin
				next_s.reset_n = 1'b1; // [RULE2]
				next_s.cnt = s.was_busy ? READY_ALG_CYCLES :
					flash_host_pkg::READY_IDLE_CYC; // [RULE3] [RULE4]
				next_s.st = flash_host_pkg::ST_BUSY_WAIT;
			end
		end
		default: begin
			next_s.st = flash_host_pkg::ST_IDLE;
		end
		endcase
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.st <= flash_host_pkg::ST_IDLE;
			s.ce_n <= 1'b1;
			s.oe_n <= 1'b1;
			s.we_n <= 1'b1; // [RULE17]
			s.reset_n <= 1'b1;
			s.cmd_ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign cmd_ready = s.cmd_ready;
	assign rsp_valid = s.rsp_valid;
	assign rsp_data = s.rsp_data;
	assign rsp_aborted = s.rsp_aborted;
	assign flash_ce_n = s.ce_n;
	assign flash_oe_n = s.oe_n;
	assign flash_we_n = s.we_n;
	assign flash_addr = s.addr;
	assign flash_dq_out = s.dq_out;
	assign flash_dq_oe = s.dq_oe;
	assign flash_reset_n = s.reset_n;
	assign reset_hv = s.reset_hv;
	assign a9_hv = s.a9_hv;

endmodule // flash_host

// File: verification/flash_dev_model.sv
// Behavioural model of the boot-sector flash on the host's pins.
// Assumes pins change on mclk edges; mclk paces the busy time.
`timescale 1ns/10ps

module flash_dev_model #(
	// The identity codes are arbitrary values.
	parameter logic [7:0] MK = 8'h00,
	parameter logic [7:0] DV = 8'h00,
	parameter logic [7:0] CN = 8'h00,
	// One bit per sector base, indexed by address bits 18..13.
	parameter logic [63:0] TOPS = 64'h7101010101010101
) (
	input wire logic mclk,
	input wire logic go_busy,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [18:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_reset_n,
	input wire logic reset_hv,
	input wire logic a9_hv,
	output logic [7:0] flash_dq_in,
	output logic ready_busy_n
);
	logic [7:0] mem [256];
	logic [7:0] val, ld, last = 8'h00, busy = 8'h00;
	logic [63:0] prot = '0;
	logic [18:0] la;
	logic [1:0] st = 2'h0;
	logic arm = 1'b0, idm = 1'b0;

	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
	assign ready_busy_n = (busy == 8'h00);
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n && flash_reset_n) ?
		val : ~last;

	always_comb begin
		val = mem[flash_addr[7:0]];
		if (a9_hv || idm) begin
			case (flash_addr[1:0])
				2'h0: val = MK;
				2'h1: val = DV;
				2'h2: val = {7'h0, prot[flash_addr[18:13]]};
				default: val = CN;
			endcase
		end
	end

	always @(posedge mclk) begin
		last <= flash_dq_in;
		if (!flash_reset_n) begin
			arm <= 1'b0;
			st <= 2'h0;
			idm <= 1'b0;
			if (busy != 8'h00) busy <= 8'h0a;
		end else if (go_busy) busy <= 8'h28;
		else if (busy != 8'h00) busy <= busy - 8'h01;
		else if (!flash_we_n && !flash_ce_n && flash_oe_n) begin
			arm <= 1'b1;
			la <= flash_addr;
			ld <= flash_dq_out;
		end else if (arm) begin
			arm <= 1'b0;
			if (reset_hv && !la[6]) prot[la[18:13]] <= 1'b1;
			else if (reset_hv && (prot & TOPS) == TOPS) prot <= '0;
			else if (reset_hv) prot <= prot;
			else if (st == 2'h3) begin
				st <= 2'h0;
				busy <= 8'h14;
				if (!prot[la[18:13]]) mem[la[7:0]] <= ld;
			end else if (ld == 8'hf0) begin
				st <= 2'h0;
				idm <= 1'b0;
			end else if (st == 2'h0 && la[10:0] == 11'h555 && ld == 8'haa) st <= 2'h1;
			else if (st == 2'h1 && ld == 8'h55) st <= 2'h2;
			else if (st == 2'h2 && ld == 8'h90) begin
				st <= 2'h0;
				idm <= 1'b1;
			end else st <= (st == 2'h2 && ld == 8'ha0) ? 2'h3 : 2'h0;
		end
	end
endmodule // flash_dev_model

// File: verification/flash_host_asserts.sv
// Assertions on the pins of the flash host controller.
// Bound to flash_host; sees its ports only.
`timescale 1ns/10ps

module flash_host_asserts (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_op,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic rsp_aborted,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic [18:0] flash_addr,
	input wire logic [7:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic flash_reset_n,
	input wire logic reset_hv,
	input wire logic a9_hv,
	input wire logic ready_busy_n
);
	logic [15:0] lo, hi;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lo <= 16'h0000;
			hi <= 16'hffff;
		end else begin
			lo <= flash_reset_n ? 16'h0000 : lo + 16'h0001;
			hi <= !flash_reset_n ? 16'h0000 : hi + {15'h0, hi != 16'hffff};
		end
	end

	sequence s_read;
		cmd_valid && cmd_ready && cmd_op == flash_host_pkg::OP_READ;
	endsequence
	sequence s_strobe;
		!flash_ce_n && !flash_oe_n && flash_we_n;
	endsequence

	a_read_strobe: assert property (s_read |=> s_strobe[*4] ##1 rsp_valid)
		else $error("read cycle strobes wrong");
	a_write_gate: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("write strobe without select");
	a_write_hold: assert property (!$stable(flash_we_n) |->
		$stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved in write");
	a_select_setup: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n))
		else $error("strobe fell before select");
	a_reset_quiet: assert property (!flash_reset_n |-> flash_ce_n && flash_we_n && !flash_dq_oe)
		else $error("bus active during reset");
	a_reset_width: assert property ($rose(flash_reset_n) |-> lo >= flash_host_pkg::RESET_PULSE_CYC)
		else $error("reset pulse too short");
	a_reset_settle: assert property (rsp_valid |-> hi >= flash_host_pkg::READY_IDLE_CYC - 16'h0002)
		else $error("answer before reset settled");
	a_abort_ready: assert property (rsp_valid && rsp_aborted |-> $past(ready_busy_n))
		else $error("abort answered while busy");
	a_id_level: assert property (a9_hv |-> flash_we_n && !flash_addr[6])
		else $error("id read levels wrong");
	a_hv_write: assert property (!flash_we_n && reset_hv |-> flash_reset_n && flash_addr[1:0] == 2'h2)
		else $error("protect write levels wrong");
endmodule // flash_host_asserts

bind flash_host flash_host_asserts flash_host_asserts_i (.mclk, .rstn,
	.cmd_valid, .cmd_op, .cmd_ready, .rsp_valid, .rsp_aborted, .flash_ce_n,
	.flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_out, .flash_dq_oe,
	.flash_reset_n, .reset_hv, .a9_hv, .ready_busy_n);

// File: verification/flash_host_tb.sv
// Self-checking bench: flash host against a behavioural flash model.
// Assumes the design package and host are compiled first.
`timescale 1ns/10ps

module flash_host_tb;
	localparam logic [7:0] MK = 8'h1c; // Arbitrary value.
	localparam logic [7:0] DV = 8'h2d; // Arbitrary value.
	localparam logic [7:0] CN = 8'h3e; // Arbitrary value.
	logic mclk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, go_busy = 1'b0;
	logic [2:0] cmd_op = 3'h0;
	logic [18:0] cmd_addr = 19'h0, a;
	logic [7:0] cmd_data = 8'h00, d, rsp_data, flash_dq_in, flash_dq_out;
	logic [7:0] sh [256];
	logic [7:0] ids [4];
	logic cmd_ready, rsp_valid, rsp_aborted, flash_ce_n, flash_oe_n;
	logic flash_we_n, flash_dq_oe, flash_reset_n, reset_hv, a9_hv;
	logic ready_busy_n;
	logic [18:0] flash_addr;
	logic bot_ce_n, bot_oe_n, bot_we_n, bot_reset_n, bot_reset_hv;
	logic bot_a9_hv, bot_ready_busy_n;
	logic [18:0] bot_addr;
	logic [7:0] bot_rsp_data, bot_dq_in, bot_dq_out;
	int fail_count = 0, check_count = 0, cyc = 0;

	flash_host #(.READY_ALG_CYCLES(16'h0014)) flash_host_i (.mclk, .rstn,
		.cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid,
		.rsp_data, .rsp_aborted, .flash_ce_n, .flash_oe_n, .flash_we_n,
		.flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
		.flash_reset_n, .reset_hv, .a9_hv, .ready_busy_n);
	flash_dev_model #(.MK(MK), .DV(DV), .CN(CN)) flash_dev_model_i (.mclk,
		.go_busy, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
		.flash_dq_out, .flash_reset_n, .reset_hv, .a9_hv, .flash_dq_in,
		.ready_busy_n);

	// Bottom boot pair, fed the same commands in lockstep.
	flash_host #(.BOTTOM_BOOT(1'b1), .READY_ALG_CYCLES(16'h0014))
		flash_host_bot_i (.mclk, .rstn, .cmd_valid, .cmd_op, .cmd_addr,
		.cmd_data, .cmd_ready(), .rsp_valid(), .rsp_data(bot_rsp_data),
		.rsp_aborted(), .flash_ce_n(bot_ce_n), .flash_oe_n(bot_oe_n),
		.flash_we_n(bot_we_n), .flash_addr(bot_addr),
		.flash_dq_in(bot_dq_in), .flash_dq_out(bot_dq_out),
		.flash_dq_oe(), .flash_reset_n(bot_reset_n),
		.reset_hv(bot_reset_hv), .a9_hv(bot_a9_hv),
		.ready_busy_n(bot_ready_busy_n));
	flash_dev_model #(.MK(MK), .DV(DV), .CN(CN),
		.TOPS(64'h010101010101011d)) flash_dev_model_bot_i (.mclk,
		.go_busy, .flash_ce_n(bot_ce_n), .flash_oe_n(bot_oe_n),
		.flash_we_n(bot_we_n), .flash_addr(bot_addr),
		.flash_dq_out(bot_dq_out), .flash_reset_n(bot_reset_n),
		.reset_hv(bot_reset_hv), .a9_hv(bot_a9_hv),
		.flash_dq_in(bot_dq_in),
		.ready_busy_n(bot_ready_busy_n));

	initial begin
		forever #20 mclk = ~mclk;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic run(input logic [2:0] op, input logic [18:0] ad,
		input logic [7:0] da);
		int n;
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = ad;
		cmd_data = da;
		@(negedge mclk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		if (n == 3000) fail_count++;
	endtask

	task automatic rd(input logic [2:0] op, input logic [18:0] ad,
		input logic [7:0] exp);
		run(op, ad, 8'h00);
		check(rsp_data, exp);
		check(bot_rsp_data, exp);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			give_verdict;
		end
	end

	initial begin
		void'($urandom(11));
		ids = '{MK, DV, 8'h00, CN};
		for (int i = 0; i < 256; i++) sh[i] = 8'(i) ^ 8'h5a;
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		rstn = 1'b1;
		for (int i = 0; i < 4; i++) begin
			a = 19'($urandom);
			rd(flash_host_pkg::OP_READ, a, sh[a[7:0]]);
		end
		rd(flash_host_pkg::OP_ID_HV, 19'h00002, 8'h00);
		for (int i = 0; i < 6; i++) begin
			a = 19'($urandom);
			d = 8'($urandom);
			run(flash_host_pkg::OP_PROGRAM, a, d);
			sh[a[7:0]] = d;
			rd(flash_host_pkg::OP_READ, a, d);
		end
		run(flash_host_pkg::OP_RESET, 19'h0, 8'h00);
		check(8'(rsp_aborted), 8'h00);
		@(negedge mclk);
		go_busy = 1'b1;
		@(negedge mclk);
		go_busy = 1'b0;
		run(flash_host_pkg::OP_RESET, 19'h0, 8'h00);
		check(8'(rsp_aborted), 8'h01);
		check(8'(ready_busy_n), 8'h01);
		rd(flash_host_pkg::OP_READ, a, d);
		run(flash_host_pkg::OP_ID_ENTER, 19'h0, 8'h00);
		for (int i = 0; i < 8; i++)
			rd(i < 4 ? flash_host_pkg::OP_READ : flash_host_pkg::OP_ID_HV,
				19'(i % 4), ids[i % 4]);
		run(flash_host_pkg::OP_ID_EXIT, 19'h0, 8'h00);
		rd(flash_host_pkg::OP_READ, 19'h0, sh[0]);
		a = 19'($urandom) & 19'h7e000;
		d = ~sh[8'h40];
		run(flash_host_pkg::OP_PROTECT, a, 8'h00);
		rd(flash_host_pkg::OP_ID_HV, a | 19'h2, 8'h01);
		run(flash_host_pkg::OP_PROGRAM, a | 19'h40, d);
		rd(flash_host_pkg::OP_READ, a | 19'h40, sh[8'h40]);
		run(flash_host_pkg::OP_UNPROTECT, a, 8'h00);
		rd(flash_host_pkg::OP_ID_HV, a | 19'h2, 8'h00);
		run(flash_host_pkg::OP_PROGRAM, a | 19'h40, d);
		rd(flash_host_pkg::OP_READ, a | 19'h40, d);
		give_verdict;
	end
endmodule // flash_host_tb
